// ### verilog/hbs_consts.svh
// Offsets, field positions, reset values and timing figures of the half-bridge control block.
`ifndef HBS_CONSTS_SVH
`define HBS_CONSTS_SVH

`define HBS_CLK_NS          20
`define HBS_SR_MIN_NS       500
`define HBS_SR_MAX_NS       80000
`define HBS_WAKE_NS         5000
`define HBS_STBY_NS         100000
`define HBS_SR_MIN_CYC      ((`HBS_SR_MIN_NS + `HBS_CLK_NS - 1) / `HBS_CLK_NS)
`define HBS_SR_MAX_CYC      (`HBS_SR_MAX_NS / `HBS_CLK_NS)
`define HBS_WAKE_CYC        (`HBS_WAKE_NS / `HBS_CLK_NS)
`define HBS_STBY_CYC        (`HBS_STBY_NS / `HBS_CLK_NS)
`define HBS_RESET_CYC       100
`define HBS_CLS_CYC         200
`define HBS_UVD_CYC         100

`define HBS_ADDR_W          12
`define HBS_OFS_CFG         12'h000
`define HBS_OFS_STATUS      12'h004
`define HBS_OFS_PINS        12'h008
`define HBS_CFG_RST         8'h05
`define HBS_LEVEL_RST       3'h0

`define HBS_ST_LEVEL_LSB    0
`define HBS_ST_FB_BIT       3
`define HBS_ST_STATE_LSB    4
`define HBS_ST_FAULT_BIT    7
`define HBS_ST_TOP_BIT      8
`define HBS_ST_BOT_BIT      9
`define HBS_ST_DIAG_LSB     10

`endif

// ### verilog/hbs_pkg.sv
// Types shared by the half-bridge control block.
`default_nettype none
package hbs_pkg;
    typedef enum logic [2:0] {
        HBS_STBY,
        HBS_WAKE,
        HBS_RUN,
        HBS_SEL,
        HBS_LATCH,
        HBS_CLIM,
        HBS_UV
    } hbs_state_e;

    typedef enum logic [2:0] {
        HBS_DIAG_HIZ,
        HBS_DIAG_OFFSET,
        HBS_DIAG_LOAD,
        HBS_DIAG_TEMP,
        HBS_DIAG_LEVEL,
        HBS_DIAG_FAULT
    } hbs_diag_e;
endpackage : hbs_pkg
`default_nettype wire

// ### verilog/hbs_pin_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module hbs_pin_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] din,
    output var  logic [W-1:0] dout
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    wire  [W-1:0] agree = ~(s2_r ^ s3_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            dout <= '0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            dout <= (s2_r & agree) | (dout & ~agree);
        end
    end
endmodule : hbs_pin_sync
`default_nettype wire

// ### verilog/hbs_bridge_ctl.sv
// Half-bridge mode decoder, slew level selection, diagnostic selection and fault handling.
//
// Functional notes
// R1: Eight selectable slew levels, zero to seven.
// R2: Selection pulses ignored while any fault; a step completing in the cycle undervoltage arrives still lands.
// R3: Controller's first pulse after stand-by exceeds wake delay.
// R4: Gate low, phase high: selection mode, switches off.
// R5: Selection entry reports control-chip temperature.
// R6: Valid low pulse advances selection on rise.
// R7: Controller keeps gate low during step pulses.
// R8: First step shows level feedback, level unchanged.
// R9: Later steps increment level, feedback follows.
// R10: Level seven steps back to zero.
// R11: Fault or gate high leaves selection.
// R12: Controller separates same-direction input edges.
// R13: Level zero after reset and stand-by.
// R14: Undervoltage outside selection keeps level.
// R15: Controller repeats selection after undervoltage.
// R16: Both high: top on, load sense.
// R17: Feedback current falls by step per level.
// R18: Offset current during step low pulse.
// R19: Both low: off, offset, then stand-by.
// R20: Stand-by: diagnostic high impedance, switches off.
// R21: Any fault: fixed fault current.
// R22: Overcurrent or overtemperature latches shutdown.
// R23: Current limit: opposite switch on, fault shown.
// R24: Gate high, phase low: bottom on, offset.
// R25: Never both on; level-dependent dead time.
// R26: Step pulse 0.5 to 80 us, gap 0.5 us.
// R27: Latch clears after both inputs low reset time.
// R28: Limit ends after period, fault after 1.5.
// R29: Undervoltage recovery after delay clears fault.
//
// Implementation choices: the placing of the registers and register access over APB.
`include "hbs_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module hbs_bridge_ctl #(
    parameter int unsigned STBY_CYC  = `HBS_STBY_CYC,
    parameter int unsigned RESET_CYC = `HBS_RESET_CYC,
    parameter int unsigned CLS_CYC   = `HBS_CLS_CYC,
    parameter int unsigned UVD_CYC   = `HBS_UVD_CYC
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`HBS_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output var  logic [31:0]            prdata,
    output var  logic                   pready,
    output var  logic                   pslverr,
    input  wire logic                   bridge_gate,
    input  wire logic                   phase_ctl,
    input  wire logic                   thermal_trip,
    input  wire logic                   overcurrent_trip,
    input  wire logic                   current_limit,
    input  wire logic                   low_supply,
    output var  logic                   top_switch,
    output var  logic                   bottom_switch,
    output var  logic [2:0]             edge_rate_level,
    output var  logic [2:0]             diag_out,
    output var  logic                   diag_oe
);
    localparam logic [15:0] SR_MIN   = 16'(`HBS_SR_MIN_CYC);
    localparam logic [15:0] SR_MAX   = 16'(`HBS_SR_MAX_CYC);
    localparam logic [15:0] WAKE_LIM = 16'(`HBS_WAKE_CYC);
    localparam logic [15:0] STBY_LIM = 16'(STBY_CYC);
    localparam logic [15:0] RST_LIM  = 16'(RESET_CYC);
    localparam logic [15:0] CLS_LIM  = 16'(CLS_CYC);
    localparam logic [15:0] HOLD_LIM = 16'((CLS_CYC * 3 + 1) / 2);
    localparam logic [15:0] UVD_LIM  = 16'(UVD_CYC);
    // Dead time grows with the slew level, since slower edges need more margin.
    function automatic logic [15:0] hbs_dead_cycles(input logic [7:0] base, input logic [2:0] lvl);
        logic [15:0] prod;
        prod = 16'({8'h00, base} * {13'h0000, lvl} + {8'h00, base});
        return prod;
    endfunction : hbs_dead_cycles
    function automatic logic [15:0] hbs_sat_inc(input logic [15:0] v);
        return (v == 16'hffff) ? v : v + 16'h0001;
    endfunction : hbs_sat_inc
    // Pin synchronisation.
    logic [5:0] pins_s;
    hbs_pin_sync #(
        .W(6)
    ) u_sync (
        .pclk   (pclk),
        .presetn(presetn),
        .din    ({low_supply, current_limit, overcurrent_trip, thermal_trip, phase_ctl, bridge_gate}),
        .dout   (pins_s)
    );
    wire gate  = pins_s[0];
    wire phase = pins_s[1];
    wire ot    = pins_s[2];
    wire oc    = pins_s[3];
    wire cl    = pins_s[4];
    wire uv    = pins_s[5];
    wire trip  = ot | oc;
    // State registers.
    hbs_pkg::hbs_state_e state_r;
    hbs_pkg::hbs_state_e state_nxt;
    logic [15:0]         cnt_r;
    logic [15:0]         cnt_nxt;
    logic [15:0]         cl_cnt_r;
    logic [15:0]         cl_cnt_nxt;
    logic [2:0]          level_r;
    logic [2:0]          level_nxt;
    logic                fb_r;
    logic                fb_nxt;
    logic                low_r;
    logic                low_nxt;
    logic [7:0]          cfg_r;
    wire cl_hold  = cl_cnt_r < HOLD_LIM;
    wire in_fault = (state_r == hbs_pkg::HBS_LATCH) || (state_r == hbs_pkg::HBS_CLIM)
                 || (state_r == hbs_pkg::HBS_UV);
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = hbs_sat_inc(cnt_r);
        level_nxt = level_r;
        fb_nxt    = fb_r;
        low_nxt   = low_r;
        case (state_r)
            hbs_pkg::HBS_STBY: begin
                cnt_nxt = 16'h0000;
                if (gate || phase) begin
                    state_nxt = hbs_pkg::HBS_WAKE;
                end
            end
            hbs_pkg::HBS_WAKE: begin
                if (cnt_r >= WAKE_LIM - 16'h0001) begin
                    state_nxt = hbs_pkg::HBS_RUN;
                    cnt_nxt   = 16'h0000;
                end
            end
            hbs_pkg::HBS_RUN: begin
                if (!gate && phase) begin
                    state_nxt = hbs_pkg::HBS_SEL; // R4
                    fb_nxt    = 1'b0; // R5
                    low_nxt   = 1'b0;
                    cnt_nxt   = 16'h0000;
                end else if (!gate && !phase) begin
                    if (cnt_r >= STBY_LIM - 16'h0001) begin
                        state_nxt = hbs_pkg::HBS_STBY; // R19
                        level_nxt = `HBS_LEVEL_RST; // R13
                    end
                end else begin
                    cnt_nxt = 16'h0000;
                end
            end
            hbs_pkg::HBS_SEL: begin
                if (gate) begin
                    state_nxt = hbs_pkg::HBS_RUN; // R11
                    cnt_nxt   = 16'h0000;
                end else if (!phase) begin
                    low_nxt = 1'b1;
                    // A low time past the longest step pulse is an idle command, not a step.
                    if (low_r && cnt_r >= SR_MAX) begin
                        state_nxt = hbs_pkg::HBS_RUN;
                    end
                end else if (low_r) begin
                    low_nxt = 1'b0;
                    cnt_nxt = 16'h0000;
                    if (cnt_r >= SR_MIN) begin // R6
                        if (!fb_r) begin
                            fb_nxt = 1'b1; // R8
                        end else begin
                            level_nxt = level_r + 3'h1; // R9 R10 R1
                        end
                    end
                end else begin
                    cnt_nxt = 16'h0000;
                end
            end
            hbs_pkg::HBS_LATCH: begin
                if (gate || phase) begin
                    cnt_nxt = 16'h0000;
                end else if (cnt_r >= RST_LIM - 16'h0001) begin
                    state_nxt = hbs_pkg::HBS_RUN; // R27
                    cnt_nxt   = 16'h0000;
                end
            end
            hbs_pkg::HBS_CLIM: begin
                if (!cl && cl_cnt_r >= CLS_LIM) begin
                    state_nxt = hbs_pkg::HBS_RUN; // R28
                    cnt_nxt   = 16'h0000;
                end
            end
            hbs_pkg::HBS_UV: begin
                if (cnt_r >= UVD_LIM - 16'h0001) begin
                    state_nxt = hbs_pkg::HBS_RUN; // R29
                    cnt_nxt   = 16'h0000;
                end
            end
            default: begin
                state_nxt = hbs_pkg::HBS_STBY;
            end
        endcase
        // Faults override the state above; only trip and current limit also hold level and feedback, so a step can still land as undervoltage arrives.
        if (uv) begin
            state_nxt = hbs_pkg::HBS_UV; // R14
            cnt_nxt   = 16'h0000;
        end else if (trip && state_r != hbs_pkg::HBS_UV) begin
            state_nxt = hbs_pkg::HBS_LATCH; // R22 R2
            cnt_nxt   = 16'h0000;
            level_nxt = level_r;
            fb_nxt    = fb_r;
        end else if (cl && state_r != hbs_pkg::HBS_UV && state_r != hbs_pkg::HBS_LATCH) begin
            state_nxt = hbs_pkg::HBS_CLIM; // R23 R2
            level_nxt = level_r;
            fb_nxt    = fb_r;
            if (state_r != hbs_pkg::HBS_CLIM) begin
                cnt_nxt = 16'h0000;
            end
        end
    end

    assign cl_cnt_nxt = cl ? 16'h0000 : (cl_hold ? cl_cnt_r + 16'h0001 : cl_cnt_r);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r  <= hbs_pkg::HBS_STBY;
            cnt_r    <= 16'h0000;
            cl_cnt_r <= HOLD_LIM;
            level_r  <= `HBS_LEVEL_RST; // R13
            fb_r     <= 1'b0;
            low_r    <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            cnt_r    <= cnt_nxt;
            cl_cnt_r <= cl_cnt_nxt; // R28
            level_r  <= level_nxt;
            fb_r     <= fb_nxt;
            low_r    <= low_nxt;
        end
    end

    // Switch requests before dead time.
    logic want_top;
    logic want_bot;
    always_comb begin
        want_top = 1'b0;
        want_bot = 1'b0;
        case (state_r)
            hbs_pkg::HBS_RUN: begin
                want_top = gate && phase; // R16
                want_bot = gate && !phase; // R24
            end
            hbs_pkg::HBS_CLIM: begin
                want_top = gate && !phase; // R23
                want_bot = gate && phase; // R23
            end
            default: begin
                want_top = 1'b0; // R4 R20 R22
                want_bot = 1'b0;
            end
        endcase
    end

    // Dead time: any turn-off reloads the timer and no turn-on happens until it has run out.
    logic        top_nxt;
    logic        bot_nxt;
    logic [15:0] dead_r;
    logic [15:0] dead_nxt;
    wire         turn_off = (top_switch && !want_top) || (bottom_switch && !want_bot);
    always_comb begin
        top_nxt  = top_switch;
        bot_nxt  = bottom_switch;
        dead_nxt = (dead_r != 16'h0000) ? dead_r - 16'h0001 : 16'h0000;
        if (turn_off) begin
            top_nxt  = top_switch && want_top;
            bot_nxt  = bottom_switch && want_bot;
            dead_nxt = hbs_dead_cycles(cfg_r, level_r); // R25
        end else if (dead_r == 16'h0000) begin
            top_nxt = want_top; // R25
            bot_nxt = want_bot && !want_top;
        end
    end

    // Diagnostic source selection.
    hbs_pkg::hbs_diag_e diag_nxt;
    always_comb begin
        case (state_r)
            hbs_pkg::HBS_STBY: diag_nxt = hbs_pkg::HBS_DIAG_HIZ; // R20
            hbs_pkg::HBS_WAKE: diag_nxt = hbs_pkg::HBS_DIAG_OFFSET;
            hbs_pkg::HBS_RUN: begin
                if (cl_hold) begin
                    diag_nxt = hbs_pkg::HBS_DIAG_FAULT; // R28
                end else if (gate && phase) begin
                    diag_nxt = hbs_pkg::HBS_DIAG_LOAD; // R16
                end else begin
                    diag_nxt = hbs_pkg::HBS_DIAG_OFFSET; // R19 R24
                end
            end
            hbs_pkg::HBS_SEL: begin
                if (!phase || low_r) begin
                    diag_nxt = hbs_pkg::HBS_DIAG_OFFSET; // R18
                end else if (fb_r) begin
                    diag_nxt = hbs_pkg::HBS_DIAG_LEVEL; // R17 R8 R9
                end else begin
                    diag_nxt = hbs_pkg::HBS_DIAG_TEMP; // R5
                end
            end
            default: diag_nxt = hbs_pkg::HBS_DIAG_FAULT; // R21
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            top_switch      <= 1'b0;
            bottom_switch   <= 1'b0;
            dead_r          <= 16'h0000;
            diag_out        <= hbs_pkg::HBS_DIAG_HIZ;
            diag_oe         <= 1'b0;
            edge_rate_level <= `HBS_LEVEL_RST;
        end else begin
            top_switch      <= top_nxt;
            bottom_switch   <= bot_nxt;
            dead_r          <= dead_nxt;
            diag_out        <= diag_nxt;
            diag_oe         <= diag_nxt != hbs_pkg::HBS_DIAG_HIZ; // R20
            edge_rate_level <= level_nxt;
        end
    end

    // APB slave: data is read in the setup cycle so the access phase answers with no wait.
    wire setup    = psel && !penable;
    wire wr_acc   = psel && penable && pwrite;
    wire hit_cfg  = paddr == `HBS_OFS_CFG;
    wire hit_stat = paddr == `HBS_OFS_STATUS;
    wire hit_pins = paddr == `HBS_OFS_PINS;
    wire mapped   = hit_cfg || hit_stat || hit_pins;
    logic [31:0] status_w;
    logic [31:0] rd_mux;
    logic        err_r;
    always_comb begin
        status_w = 32'h0000_0000;
        status_w[`HBS_ST_LEVEL_LSB +: 3] = level_r;
        status_w[`HBS_ST_FB_BIT]         = fb_r;
        status_w[`HBS_ST_STATE_LSB +: 3] = state_r;
        status_w[`HBS_ST_FAULT_BIT]      = in_fault || cl_hold;
        status_w[`HBS_ST_TOP_BIT]        = top_switch;
        status_w[`HBS_ST_BOT_BIT]        = bottom_switch;
        status_w[`HBS_ST_DIAG_LSB +: 3]  = diag_out;
    end

    assign rd_mux = hit_cfg  ? {24'h00_0000, cfg_r} :
                    hit_stat ? status_w :
                    hit_pins ? {26'h000_0000, pins_s} : 32'h0000_0000;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && err_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            err_r  <= 1'b0;
            cfg_r  <= `HBS_CFG_RST;
        end else begin
            if (setup) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_mux;
                err_r  <= !mapped;
            end
            if (wr_acc && hit_cfg) begin
                cfg_r <= pwdata[7:0];
            end
        end
    end
endmodule : hbs_bridge_ctl
`default_nettype wire

// ### bench/hbs_asserts.sv
// Concurrent checks on the half-bridge control block ports.
`timescale 1ns/1ps
`default_nettype none
module hbs_asserts (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       thermal_trip,
    input  wire logic       overcurrent_trip,
    input  wire logic       top_switch,
    input  wire logic       bottom_switch,
    input  wire logic [2:0] edge_rate_level,
    input  wire logic [2:0] diag_out,
    input  wire logic       diag_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_no_shoot: assert property (!(top_switch && bottom_switch))
        else $error("Both switches on");
    a_dead_gap: assert property ($rose(bottom_switch) |-> !$past(top_switch, 2))
        else $error("No dead time before bottom switch");
    a_stby_hiz: assert property (!diag_oe |-> diag_out == hbs_pkg::HBS_DIAG_HIZ && !top_switch && !bottom_switch)
        else $error("Stand-by outputs wrong");
    a_sel_off: assert property (diag_out == hbs_pkg::HBS_DIAG_TEMP |-> !top_switch && !bottom_switch)
        else $error("Switch on in selection");
    // Eight cycles cover the pin synchroniser plus the state and output stages.
    a_trip_fault: assert property ((thermal_trip && diag_oe)[*8] |->
        diag_out == hbs_pkg::HBS_DIAG_FAULT && !top_switch && !bottom_switch)
        else $error("Thermal trip not shut down");
    a_oc_fault: assert property ((overcurrent_trip && diag_oe)[*8] |-> ##1
        diag_out == hbs_pkg::HBS_DIAG_FAULT) else $error("Overcurrent not flagged");
    a_level_step: assert property ($changed(edge_rate_level) |->
        edge_rate_level == $past(edge_rate_level) + 3'h1 || edge_rate_level == 3'h0)
        else $error("Level jumped");
    // The level moves while the pulse still shows offset, so the feedback code follows one edge later.
    a_level_fb: assert property ($changed(edge_rate_level) && edge_rate_level != 3'h0 |=>
        diag_out == hbs_pkg::HBS_DIAG_LEVEL) else $error("New level without feedback");
    a_top_diag: assert property (top_switch |->
        diag_out inside {hbs_pkg::HBS_DIAG_LOAD, hbs_pkg::HBS_DIAG_FAULT})
        else $error("Top on with wrong diagnosis");
    a_bot_diag: assert property (bottom_switch |->
        diag_out inside {hbs_pkg::HBS_DIAG_OFFSET, hbs_pkg::HBS_DIAG_FAULT})
        else $error("Bottom on with wrong diagnosis");
    a_dead_top: assert property ($rose(top_switch) |-> !$past(bottom_switch, 2))
        else $error("No dead time before top switch");
    c_level_top: cover property (diag_out == hbs_pkg::HBS_DIAG_LEVEL && edge_rate_level == 3'h7);
    c_climit: cover property (bottom_switch && diag_out == hbs_pkg::HBS_DIAG_FAULT);
    c_wake: cover property (!diag_oe ##1 diag_oe);
endmodule : hbs_asserts
bind hbs_bridge_ctl hbs_asserts chk_u (
    .pclk            (pclk),
    .presetn         (presetn),
    .thermal_trip    (thermal_trip),
    .overcurrent_trip(overcurrent_trip),
    .top_switch      (top_switch),
    .bottom_switch   (bottom_switch),
    .edge_rate_level (edge_rate_level),
    .diag_out        (diag_out),
    .diag_oe         (diag_oe)
);
`default_nettype wire

// ### bench/hbs_mcu_model.sv
// Controller model driving the gate and phase logic inputs.
`timescale 1ns/1ps
`default_nettype none
module hbs_mcu_model #(
    parameter int GAP = 25
) (
    input  wire logic pclk,
    output var  logic bridge_gate,
    output var  logic phase_ctl
);
    initial begin
        bridge_gate = 1'b0;
        phase_ctl = 1'b0;
    end
    // Edges in the same direction are split by the lag gap, gate first.
    task automatic drive(input logic g, input logic p);
        if (g != bridge_gate && p != phase_ctl && g == p) begin
            @(posedge pclk);
            bridge_gate <= g;
            repeat (GAP) @(posedge pclk);
        end
        @(posedge pclk);
        bridge_gate <= g;
        phase_ctl <= p;
        repeat (GAP) @(posedge pclk);
    endtask : drive
    // The gate is never touched here, so it keeps its level through the pulse.
    task automatic step(input int low_cyc);
        @(posedge pclk);
        phase_ctl <= 1'b0;
        repeat (low_cyc) @(posedge pclk);
        phase_ctl <= 1'b1;
        repeat (2 * GAP) @(posedge pclk);
    endtask : step
endmodule : hbs_mcu_model
`default_nettype wire

// ### bench/hbs_bridge_ctl_tb_top.sv
// Self-checking testbench of the half-bridge control block.
`include "hbs_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module hbs_bridge_ctl_tb_top;
    localparam logic [2:0] D_OFF = hbs_pkg::HBS_DIAG_OFFSET;
    localparam logic [2:0] D_LOAD = hbs_pkg::HBS_DIAG_LOAD;
    localparam logic [2:0] D_TEMP = hbs_pkg::HBS_DIAG_TEMP;
    localparam logic [2:0] D_LVL = hbs_pkg::HBS_DIAG_LEVEL;
    localparam logic [2:0] D_FLT = hbs_pkg::HBS_DIAG_FAULT;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, top_switch, bottom_switch, diag_oe;
    logic        thermal_trip = 1'b0, overcurrent_trip = 1'b0, current_limit = 1'b0, low_supply = 1'b0;
    logic [2:0]  edge_rate_level, diag_out;
    wire logic   bridge_gate, phase_ctl;
    int          errors = 0, compares = 0, cyc = 0;
    always #10 pclk = ~pclk;
    hbs_mcu_model mcu_u (.pclk(pclk), .bridge_gate(bridge_gate), .phase_ctl(phase_ctl));
    hbs_bridge_ctl #(.STBY_CYC(50), .RESET_CYC(10), .CLS_CYC(20), .UVD_CYC(10)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bridge_gate(bridge_gate),
        .phase_ctl(phase_ctl), .thermal_trip(thermal_trip), .overcurrent_trip(overcurrent_trip),
        .current_limit(current_limit), .low_supply(low_supply), .top_switch(top_switch),
        .bottom_switch(bottom_switch), .edge_rate_level(edge_rate_level), .diag_out(diag_out), .diag_oe(diag_oe));
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Waits, bounded to 600 cycles, for the expected output set, then compares it.
    task automatic expect_out(input logic t, input logic b, input logic [2:0] d, input logic [2:0] l);
        int n;
        n = 0;
        @(negedge pclk);
        while ({top_switch, bottom_switch, diag_out, edge_rate_level} !== {t, b, d, l} && n < 600) begin
            @(negedge pclk);
            n++;
        end
        check({top_switch, bottom_switch, diag_out, edge_rate_level}, {t, b, d, l});
    endtask : expect_out
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic test_regs;
        apb(1'b0, `HBS_OFS_CFG, 32'h0);
        check(rd, {24'h0, `HBS_CFG_RST});
        apb(1'b1, `HBS_OFS_CFG, 32'h3);
        apb(1'b0, `HBS_OFS_CFG, 32'h0);
        check(rd, 32'h3);
        apb(1'b0, 12'h010, 32'h0);
        check({err, rd}, {1'b1, 32'h0});
    endtask : test_regs
    task automatic test_select;
        mcu_u.drive(1'b0, 1'b1);
        expect_out(1'b0, 1'b0, D_TEMP, 3'h0);
        mcu_u.step(10);
        expect_out(1'b0, 1'b0, D_TEMP, 3'h0);
        fork
            mcu_u.step(30);
            begin
                repeat (25) @(negedge pclk);
                check(diag_out, D_OFF);
            end
        join
        expect_out(1'b0, 1'b0, D_LVL, 3'h0);
        for (int i = 1; i <= 9; i++) begin
            mcu_u.step(i == 4 ? 3000 : 30);
            expect_out(1'b0, 1'b0, D_LVL, 3'(i));
        end
        apb(1'b1, `HBS_OFS_STATUS, 32'hffff_ffff);
        apb(1'b0, `HBS_OFS_STATUS, 32'h0);
        check(rd[2:0], 3'h1);
        mcu_u.drive(1'b1, 1'b1);
        expect_out(1'b1, 1'b0, D_LOAD, 3'h1);
    endtask : test_select
    task automatic test_faults;
        @(posedge pclk);
        low_supply <= 1'b1;
        expect_out(1'b0, 1'b0, D_FLT, 3'h1);
        @(posedge pclk);
        low_supply <= 1'b0;
        expect_out(1'b1, 1'b0, D_LOAD, 3'h1);
        mcu_u.drive(1'b0, 1'b1);
        expect_out(1'b0, 1'b0, D_TEMP, 3'h1);
        @(posedge pclk);
        low_supply <= 1'b1;
        expect_out(1'b0, 1'b0, D_FLT, 3'h1);
        @(posedge pclk);
        low_supply <= 1'b0;
        expect_out(1'b0, 1'b0, D_TEMP, 3'h1);
        mcu_u.step(30);
        expect_out(1'b0, 1'b0, D_LVL, 3'h1);
        mcu_u.drive(1'b1, 1'b1);
        expect_out(1'b1, 1'b0, D_LOAD, 3'h1);
        @(posedge pclk);
        current_limit <= 1'b1;
        expect_out(1'b0, 1'b1, D_FLT, 3'h1);
        @(posedge pclk);
        current_limit <= 1'b0;
        expect_out(1'b1, 1'b0, D_FLT, 3'h1);
        expect_out(1'b1, 1'b0, D_LOAD, 3'h1);
        for (int i = 0; i < 2; i++) begin
            mcu_u.drive(1'(i), 1'b1);
            expect_out(1'(i), 1'b0, i ? D_LOAD : D_TEMP, 3'h1);
            @(posedge pclk);
            thermal_trip <= !i[0];
            overcurrent_trip <= i[0];
            expect_out(1'b0, 1'b0, D_FLT, 3'h1);
            mcu_u.step(30);
            @(posedge pclk);
            thermal_trip <= 1'b0;
            overcurrent_trip <= 1'b0;
            expect_out(1'b0, 1'b0, D_FLT, 3'h1);
            mcu_u.drive(1'b0, 1'b0);
            expect_out(1'b0, 1'b0, D_OFF, 3'h1);
        end
    endtask : test_faults
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            errors++;
            stop_test();
        end
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        expect_out(1'b0, 1'b0, hbs_pkg::HBS_DIAG_HIZ, 3'h0);
        test_regs();
        // The gate input stays high beyond the wake delay; phase rises one gap after it.
        mcu_u.drive(1'b1, 1'b1);
        expect_out(1'b1, 1'b0, D_LOAD, 3'h0);
        mcu_u.drive(1'b1, 1'b0);
        expect_out(1'b0, 1'b1, D_OFF, 3'h0);
        test_select();
        test_faults();
        expect_out(1'b0, 1'b0, hbs_pkg::HBS_DIAG_HIZ, 3'h0);
        check(diag_oe, 1'b0);
        stop_test();
    end
endmodule : hbs_bridge_ctl_tb_top
`default_nettype wire
